// ---- verilog/jpmc_top.sv ----
// Purpose: Power mode sequencer for a headset jack audio interface.
// Assumes: Control bits arrive from a register block on the same clock; jack pins are async.
// Notes: Flag clears are one-cycle pulses; a set in the same cycle wins.
`timescale 1ns/1ps
module jpmc_top #(
	parameter int DET_CYCLES = 16 // Detection test duration
) (
	input wire logic i_ref_clk, // 10 MHz clock
	input wire logic i_arst_n, // Async reset, active low
	input wire logic i_run_bit, // Run bit (register domain)
	input wire logic i_det_reset, // Detection reset bit
	input wire logic [7:0] i_policy_reg, // Register 0x1E contents
	input wire logic i_jack_pin, // Jack switch, async
	input wire logic i_key_pin, // Hook switch comparator, async
	input wire logic [4:0] i_sense_pins, // Load sense, async
	input wire logic [4:0] i_host_enables, // Host enables: mic bias, preamp, ks, left, right
	input wire logic [5:0] i_volume, // Volume code
	input wire logic i_mute, // Volume mute bits
	input wire logic i_ramp_disable_bit, // Disables slewing
	input wire logic [4:0] i_irq_en, // inserted, switch, done, key, ramp
	input wire logic [4:0] i_flag_clr, // Clear pulses, same order
	output logic [1:0] o_mode, // Power mode
	output logic [4:0] o_flags, // inserted, switch, done, key, ramp
	output logic o_irq, // Interrupt request
	output logic [4:0] o_found, // mic, line_l, line_r, hp_l, hp_r
	output logic o_mic_bias_en, // Mic bias enable
	output logic o_preamp_en, // Mic preamp enable
	output logic o_key_sense_en, // Key decoder enable
	output logic o_left_amp_enable, // Left amp enable
	output logic o_right_amp_enable, // Right amp enable
	output logic o_weak_pullup_en, // Weak mic pullup
	output logic o_plug_test_en, // Plug-in test signal
	output logic [5:0] o_level, // Applied volume
	output logic o_amp_mute // Amplifier mute
);
	localparam int F_INS = 0;
	localparam int F_SW = 1;
	localparam int F_DONE = 2;
	localparam int F_KEY = 3;
	localparam int F_RAMP = 4;

	// ************************************************
	// Input synchronisers
	// ************************************************
	logic [6:0] sync1_q;
	logic [6:0] sync2_q;
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync1_q <= 7'h00;
			sync2_q <= 7'h00;
		end else begin
			sync1_q <= {i_sense_pins, i_key_pin, i_jack_pin};
			sync2_q <= sync1_q;
		end
	end
	logic jack_s;
	logic key_s;
	assign jack_s = sync2_q[0];
	assign key_s = sync2_q[1];

	// ************************************************
	// Edge and policy decode
	// ************************************************
	logic run_q;
	logic rst_q;
	logic jack_q;
	logic key_q;
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			run_q <= 1'b0;
			rst_q <= 1'b0;
			jack_q <= 1'b0;
			key_q <= 1'b0;
		end else begin
			run_q <= i_run_bit;
			rst_q <= i_det_reset;
			jack_q <= jack_s;
			key_q <= key_s;
		end
	end
	logic run_rise;
	logic run_fall;
	logic rst_fall;
	logic jack_rise;
	logic key_rise;
	assign run_rise = i_run_bit && !run_q;
	assign run_fall = !i_run_bit && run_q;
	assign rst_fall = !i_det_reset && rst_q;
	assign jack_rise = jack_s && !jack_q;
	assign key_rise = key_s && !key_q;

	logic [1:0] policy;
	assign policy = i_policy_reg[jpmc_pkg::POLICY_LSB +: 2];
	logic self_en;
	assign self_en = (policy == jpmc_pkg::POLICY_AFTER_RUN) ||
		(policy == jpmc_pkg::POLICY_IMMEDIATE);

	// ************************************************
	// Detector
	// ************************************************
	jpmc_det_if det_bus ();
	jpmc_detector #(.DET_CYCLES(DET_CYCLES)) u_det (
		.i_ref_clk(i_ref_clk),
		.i_arst_n(i_arst_n),
		.i_sense(sync2_q[6:2]),
		.det(det_bus.det)
	);

	// ************************************************
	// Mode sequencer
	// ************************************************
	jpmc_pkg::jpmc_mode_e mode_q;
	logic inserted_q;
	logic detected_q;
	logic pending_q;
	logic key_wake_q;
	logic start_c;
	logic clear_c;

	// Detection is launched by insertion under policy 2 and by the run edge otherwise
	always_comb begin
		start_c = 1'b0;
		if (!i_det_reset && !pending_q && !detected_q) begin
			if (policy == jpmc_pkg::POLICY_IMMEDIATE) begin
				start_c = jack_rise || (inserted_q && rst_fall);
			end else begin
				start_c = inserted_q && run_rise;
			end
		end
	end
	assign clear_c = i_det_reset || !jack_s;
	assign det_bus.start = start_c;
	assign det_bus.clear = clear_c;

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mode_q <= jpmc_pkg::JPMC_DETECTION;
			inserted_q <= 1'b0;
			detected_q <= 1'b0;
			pending_q <= 1'b0;
			key_wake_q <= 1'b0;
		end else begin
			inserted_q <= jack_s;
			if (clear_c) begin
				mode_q <= jpmc_pkg::JPMC_DETECTION;
				detected_q <= 1'b0;
				pending_q <= 1'b0;
				key_wake_q <= 1'b0;
			end else begin
				if (start_c) begin
					pending_q <= 1'b1;
				end
				if (det_bus.done) begin
					pending_q <= 1'b0;
					detected_q <= 1'b1;
				end
				case (mode_q)
					jpmc_pkg::JPMC_DETECTION: begin
						if (det_bus.done) begin
							mode_q <= i_run_bit ? jpmc_pkg::JPMC_NORMAL
								: jpmc_pkg::JPMC_STANDBY;
						end else if (detected_q && run_rise) begin
							mode_q <= jpmc_pkg::JPMC_NORMAL;
						end
					end
					jpmc_pkg::JPMC_NORMAL: begin
						if (run_fall) begin
							mode_q <= jpmc_pkg::JPMC_STANDBY;
						end
					end
					jpmc_pkg::JPMC_STANDBY: begin
						if (detected_q && key_rise) begin
							key_wake_q <= 1'b1;
						end
						if (key_wake_q && run_rise) begin
							mode_q <= jpmc_pkg::JPMC_DETECTION;
							key_wake_q <= 1'b0;
						end else if (run_rise && detected_q) begin
							mode_q <= jpmc_pkg::JPMC_NORMAL;
						end
					end
					default: mode_q <= jpmc_pkg::JPMC_DETECTION;
				endcase
			end
		end
	end

	// ************************************************
	// Block enables
	// ************************************************
	logic [4:0] found;
	logic [4:0] auto_en;
	logic [4:0] en_q;
	assign found = det_bus.found;
	assign auto_en = {found[2] | found[4], found[1] | found[3], found[0], found[0], found[0]};

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			en_q <= 5'h00;
		end else if (!self_en) begin
			en_q <= i_host_enables;
		end else if (!detected_q) begin
			en_q <= 5'h00;
		end else begin
			en_q <= auto_en;
		end
	end

	logic in_standby;
	assign in_standby = (mode_q == jpmc_pkg::JPMC_STANDBY);
	// Amps stay dark outside normal mode, so policy 2 standby holds them off
	logic amps_on;
	assign amps_on = (mode_q == jpmc_pkg::JPMC_NORMAL);

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_mic_bias_en <= 1'b0;
			o_preamp_en <= 1'b0;
			o_key_sense_en <= 1'b0;
			o_left_amp_enable <= 1'b0;
			o_right_amp_enable <= 1'b0;
			o_weak_pullup_en <= 1'b0;
			o_plug_test_en <= 1'b0;
		end else begin
			o_mic_bias_en <= en_q[0] && amps_on;
			o_preamp_en <= en_q[1] && amps_on;
			o_key_sense_en <= (en_q[2] && amps_on) || (in_standby && detected_q);
			o_left_amp_enable <= en_q[3] && amps_on;
			o_right_amp_enable <= en_q[4] && amps_on;
			o_weak_pullup_en <= in_standby && detected_q;
			o_plug_test_en <= !i_det_reset;
		end
	end

	// ************************************************
	// Volume ramp
	// ************************************************
	logic [15:0] tick_cnt_q;
	logic tick;
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tick_cnt_q <= 16'h0000;
		end else if (tick) begin
			tick_cnt_q <= 16'h0000;
		end else begin
			tick_cnt_q <= tick_cnt_q + 16'h0001;
		end
	end
	assign tick = (tick_cnt_q == 16'(jpmc_pkg::STEP_CYCLES - 1));

	logic [5:0] target;
	logic ramp_done;
	assign target = i_mute ? jpmc_pkg::VOL_RESET : i_volume;
	jpmc_ramp #(.W(jpmc_pkg::VOL_W)) u_ramp (
		.i_ref_clk(i_ref_clk),
		.i_arst_n(i_arst_n),
		.i_tick(tick),
		.i_slew_off(i_ramp_disable_bit),
		.i_target(target),
		.o_level(o_level),
		.o_done(ramp_done)
	);

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_amp_mute <= 1'b1;
		end else begin
			// With slewing off the mute must not wait for the level register
			o_amp_mute <= (o_level == jpmc_pkg::VOL_RESET) || !amps_on ||
				(i_ramp_disable_bit && target == jpmc_pkg::VOL_RESET);
		end
	end

	// ************************************************
	// Status flags and interrupt
	// ************************************************
	logic [4:0] flag_set;
	assign flag_set = {ramp_done, (in_standby && detected_q && key_rise), det_bus.done,
		jack_rise, jack_rise};

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_flags <= 5'h00;
		end else begin
			o_flags <= flag_set | (o_flags & ~i_flag_clr);
		end
	end

	assign o_irq = |(o_flags & i_irq_en);
	assign o_mode = mode_q;
	assign o_found = found;
endmodule // jpmc_top

// ---- verilog/jpmc_pkg.sv ----
// Purpose: Shared constants and types for the jack power mode controller.
// Assumes: 10 MHz reference clock.
// Notes: Policy codes sit in the two low bits of the self-enable policy field.
package jpmc_pkg;

	// ************************************************
	// Self-enable policy
	// ************************************************
	localparam logic [7:0] POLICY_REG_ADDR = 8'h1E;
	localparam int POLICY_LSB = 0;
	localparam logic [1:0] POLICY_USER = 2'h0;
	localparam logic [1:0] POLICY_AFTER_RUN = 2'h1;
	localparam logic [1:0] POLICY_IMMEDIATE = 2'h2;

	// ************************************************
	// Timing
	// ************************************************
	localparam int CLK_HZ = 10000000;
	localparam int STEP_TIME_US = 1000;
	localparam int STEP_CYCLES = CLK_HZ / 1000000 * STEP_TIME_US;

	// ************************************************
	// Volume and reset values
	// ************************************************
	localparam int VOL_W = 6;
	localparam logic [5:0] VOL_RESET = 6'h00;

	typedef enum logic [1:0] {
		JPMC_DETECTION,
		JPMC_NORMAL,
		JPMC_STANDBY
	} jpmc_mode_e;

endpackage

// ---- verilog/jpmc_det_if.sv ----
`timescale 1ns/1ps
// Purpose: Carries the configuration-detection handshake between the controller and detector.
// Assumes: One clock domain.
// Notes: start is a one-cycle pulse; done is a one-cycle pulse.
interface jpmc_det_if;
	logic start;
	logic clear;
	logic done;
	logic [4:0] found;

	modport ctrl (output start, output clear, input done, input found);
	modport det (input start, input clear, output done, output found);
endinterface

// ---- verilog/jpmc_detector.sv ----
`timescale 1ns/1ps
// Purpose: Latches the load configuration sensed by the analog tests.
// Assumes: i_sense comes from synchronised analog comparators.
// Notes: found bits are mic, line_l, line_r, hp_l, hp_r.
module jpmc_detector #(
	parameter int DET_CYCLES = 16 // Settling time of the tests
) (
	input wire logic i_ref_clk, // Clock
	input wire logic i_arst_n, // Async reset
	input wire logic [4:0] i_sense, // Sensed loads
	jpmc_det_if.det det // Handshake
);
	initial begin
		if (DET_CYCLES < 1 || DET_CYCLES > 65535) begin
			$error("DET_CYCLES out of range");
		end
	end

	logic [15:0] cnt_q;
	logic busy_q;
	logic done_q;
	logic [4:0] found_q;

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_q <= 16'h0000;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			found_q <= 5'h00;
		end else begin
			done_q <= 1'b0;
			if (det.clear) begin
				busy_q <= 1'b0;
				found_q <= 5'h00;
			end else if (det.start) begin
				busy_q <= 1'b1;
				cnt_q <= 16'(DET_CYCLES - 1);
			end else if (busy_q) begin
				if (cnt_q == 16'h0000) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
					found_q <= i_sense;
				end else begin
					cnt_q <= cnt_q - 16'h0001;
				end
			end
		end
	end

	assign det.done = done_q;
	assign det.found = found_q;
endmodule // jpmc_detector

// ---- verilog/jpmc_ramp.sv ----
`timescale 1ns/1ps
// Purpose: Slews the applied volume toward the target one step per tick.
// Assumes: i_tick is a one-cycle enable.
// Notes: With slewing off the target is applied at once.
module jpmc_ramp #(
	parameter int W = jpmc_pkg::VOL_W // Volume code width
) (
	input wire logic i_ref_clk, // Clock
	input wire logic i_arst_n, // Async reset
	input wire logic i_tick, // Step enable
	input wire logic i_slew_off, // Ramp disable
	input wire logic [W-1:0] i_target, // Target code
	output logic [W-1:0] o_level, // Applied code
	output logic o_done // Slew finished pulse
);
	initial begin
		if (W < 1 || W > 16) begin
			$error("W out of range");
		end
	end

	logic [W-1:0] lvl_q;
	logic done_q;
	logic moving_q;

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lvl_q <= '0;
			done_q <= 1'b0;
			moving_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (i_slew_off) begin
				lvl_q <= i_target;
				moving_q <= 1'b0;
			end else if (lvl_q != i_target) begin
				moving_q <= 1'b1;
				if (i_tick) begin
					lvl_q <= (lvl_q < i_target) ? lvl_q + 1'b1 : lvl_q - 1'b1;
				end
			end else if (moving_q) begin
				moving_q <= 1'b0;
				done_q <= 1'b1;
			end
		end
	end

	assign o_level = lvl_q;
	assign o_done = done_q;
endmodule // jpmc_ramp

// ---- sim/jpmc_asserts.sv ----
// Purpose: Concurrent checks on the jack power mode controller ports.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Mode codes are 0 detection, 1 normal, 2 standby.
`timescale 1ns/1ps
module jpmc_asserts #(
	parameter int DET_CYCLES = 16 // Detection test duration
) (
	input wire logic i_ref_clk, // Clock
	input wire logic i_arst_n, // Reset
	input wire logic i_run_bit, // Run bit
	input wire logic i_det_reset, // Detection reset
	input wire logic [7:0] i_policy_reg, // Policy register
	input wire logic [5:0] i_volume, // Volume code
	input wire logic i_mute, // Mute
	input wire logic i_ramp_disable_bit, // Slew off
	input wire logic [4:0] i_irq_en, // Flag enables
	input wire logic [1:0] o_mode, // Mode
	input wire logic [4:0] o_flags, // Flags
	input wire logic o_irq, // Interrupt
	input wire logic [4:0] o_found, // Result
	input wire logic o_weak_pullup_en, // Pullup
	input wire logic o_plug_test_en, // Plug test
	input wire logic [5:0] o_level, // Applied volume
	input wire logic o_amp_mute // Amp mute
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_arst_n);

	// ************
	// Checks
	// ************
	AST_PLUG: assert property ($past(i_arst_n) |-> o_plug_test_en == !$past(i_det_reset))
		else $error("plug test level wrong");
	AST_IRQ: assert property (o_irq == |(o_flags & i_irq_en))
		else $error("interrupt level wrong");
	AST_DET_RESET: assert property (i_det_reset |=> o_mode == 2'h0 && o_found == 5'h00)
		else $error("detection reset ignored");
	AST_STANDBY: assert property (o_mode == 2'h1 && !i_run_bit && !i_det_reset |=> o_mode == 2'h2)
		else $error("standby not entered");
	AST_P2_DONE: assert property (i_policy_reg[1:0] == 2'h2 && $rose(o_flags[2]) && !i_run_bit
		|-> o_mode == 2'h2)
		else $error("no standby after detection");
	AST_WAKE: assert property (o_mode == 2'h2 && !o_flags[3] && !i_det_reset && $rose(i_run_bit)
		|=> o_mode == 2'h1)
		else $error("normal mode not entered");
	AST_KEY: assert property (o_mode == 2'h2 && o_flags[3] && !i_det_reset && $rose(i_run_bit)
		|=> o_mode == 2'h0)
		else $error("detection not entered after key");
	AST_PULLUP: assert property (o_weak_pullup_en |-> o_mode == 2'h2 || $past(o_mode) == 2'h2)
		else $error("pullup outside standby");
	AST_MUTE: assert property (i_ramp_disable_bit && (i_mute || i_volume == 6'h00) |=> o_amp_mute)
		else $error("mute late");
	AST_STEP: assert property (!i_ramp_disable_bit && $changed(o_level)
		|=> ($stable(o_level) || i_ramp_disable_bit) [*8])
		else $error("volume stepped too fast");
	COV_NORMAL: cover property (o_mode == 2'h1);
	COV_KEY: cover property (o_flags[3]);
	COV_RAMP: cover property ($rose(o_flags[4]));
endmodule // jpmc_asserts

bind jpmc_top jpmc_asserts #(.DET_CYCLES(DET_CYCLES)) jpmc_asserts_inst (.i_ref_clk, .i_arst_n,
	.i_run_bit, .i_det_reset, .i_policy_reg, .i_volume, .i_mute, .i_ramp_disable_bit, .i_irq_en,
	.o_mode, .o_flags, .o_irq, .o_found, .o_weak_pullup_en, .o_plug_test_en, .o_level, .o_amp_mute);

// ---- sim/jpmc_host_model.sv ----
// Purpose: Host that writes block enables from each fresh detection result.
// Assumes: Reply delay set by i_slow.
// Notes: Only matters under the user policy and policy code 3.
`timescale 1ns/1ps
module jpmc_host_model (
	input wire logic i_ref_clk, // Clock
	input wire logic i_arst_n, // Reset
	input wire logic [7:0] i_slow, // Reply delay cycles
	input wire logic [4:0] i_flags, // Device flags
	input wire logic [4:0] i_found, // Device result
	output logic [4:0] o_host_enables // Enables written
);
	logic [7:0] wait_q;

	// Every found load gets its block, else unplug sensing goes blind
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wait_q <= 8'h00;
			o_host_enables <= 5'h00;
		end else if (!i_flags[2]) begin
			wait_q <= i_slow;
		end else if (wait_q != 8'h00) begin
			wait_q <= wait_q - 8'h01;
		end else begin
			o_host_enables <= {i_found[2] | i_found[4], i_found[1] | i_found[3], {3{i_found[0]}}};
		end
	end
endmodule // jpmc_host_model

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the jack power mode controller.
// Assumes: 10 MHz clock, host model answering at a random delay.
// Notes: Mode changes are matched against a queue of expected modes.
`timescale 1ns/1ps
module tb_top;
	logic i_ref_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic i_run_bit = 1'b0;
	logic i_det_reset = 1'b0;
	logic [7:0] i_policy_reg = 8'h00;
	logic i_jack_pin = 1'b0;
	logic i_key_pin = 1'b0;
	logic [4:0] i_sense_pins = 5'h00;
	logic [4:0] i_host_enables;
	logic [5:0] i_volume = 6'h00;
	logic i_mute = 1'b0;
	logic i_ramp_disable_bit = 1'b0;
	logic [4:0] i_irq_en = 5'h00;
	logic [4:0] i_flag_clr = 5'h00;
	logic [7:0] slow = 8'h00;
	logic [1:0] o_mode;
	logic [4:0] o_flags, o_found;
	logic o_irq, o_mic_bias_en, o_preamp_en, o_key_sense_en, o_left_amp_enable;
	logic o_right_amp_enable, o_weak_pullup_en, o_plug_test_en, o_amp_mute;
	logic [5:0] o_level;
	logic [1:0] exp_q[$];
	logic [1:0] last_mode = 2'h0;
	logic [4:0] s;
	int n, cycles, failures, total_checks;

	jpmc_top #(.DET_CYCLES(4)) jpmc_top_inst (.i_ref_clk, .i_arst_n, .i_run_bit, .i_det_reset,
		.i_policy_reg, .i_jack_pin, .i_key_pin, .i_sense_pins, .i_host_enables, .i_volume,
		.i_mute, .i_ramp_disable_bit, .i_irq_en, .i_flag_clr, .o_mode, .o_flags, .o_irq,
		.o_found, .o_mic_bias_en, .o_preamp_en, .o_key_sense_en, .o_left_amp_enable,
		.o_right_amp_enable, .o_weak_pullup_en, .o_plug_test_en, .o_level, .o_amp_mute);
	jpmc_host_model jpmc_host_model_inst (.i_ref_clk, .i_arst_n, .i_slow(slow), .i_flags(o_flags),
		.i_found(o_found), .o_host_enables(i_host_enables));

	initial begin
		forever #50 i_ref_clk = ~i_ref_clk;
	end

	// ************
	// Checking
	// ************
	task automatic chk_vec(input logic [5:0] got, input logic [5:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: flag got %b expected %b", $time, got, exp);
		end
	endtask

	task automatic complete_run;
		if (exp_q.size() != 0) failures++;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// Sampled on the falling edge so the registered mode has settled
	always @(negedge i_ref_clk) begin
		if (i_arst_n && o_mode !== last_mode) begin
			if (exp_q.size() == 0) chk_bit(1'b0, 1'b1);
			else chk_vec(6'(o_mode), 6'(exp_q.pop_front()));
		end
		last_mode = o_mode;
	end

	// Ceiling covers two volume steps plus the mode scenarios with margin
	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			complete_run();
		end
	end

	// ************
	// Stimulus
	// ************
	task automatic tick(input int k);
		repeat (k) @(posedge i_ref_clk);
		#1;
	endtask

	// A random partial clear first, checked against the masked flags, then a full clear
	task automatic clear_flags;
		logic [4:0] m;
		logic [4:0] f;
		m = 5'($urandom);
		f = o_flags;
		i_flag_clr = m;
		tick(1);
		i_flag_clr = 5'h1F;
		chk_vec(6'(o_flags), 6'(f & ~m));
		tick(1);
		i_flag_clr = 5'h00;
		tick(1);
	endtask

	initial begin
		void'($urandom(32'h245EE4FE));
		tick(12);
		i_arst_n = 1'b1;
		tick(2);
		chk_vec(6'(o_mode), 6'h00);
		chk_bit(o_plug_test_en, 1'b1);
		for (int p = 0; p < 3; p++) begin
			s = 5'($urandom) | ((p == 1) ? 5'h01 : 5'h00);
			i_policy_reg = {6'($urandom), 2'(p)};
			slow = 8'($urandom_range(31));
			i_irq_en = {2'($urandom), 3'h7};
			i_sense_pins = s;
			i_jack_pin = 1'b1;
			repeat (20) if (o_flags[0] !== 1'b1) tick(1);
			chk_vec(6'(o_flags), 6'h03);
			if (p == 2) exp_q.push_back(2'h2);
			else begin
				i_run_bit = 1'b1;
				exp_q.push_back(2'h1);
			end
			repeat (40) if (o_flags[2] !== 1'b1) tick(1);
			chk_vec(6'(o_found), 6'(s));
			chk_bit(o_irq, 1'b1);
			if (p == 2) begin
				i_run_bit = 1'b1;
				exp_q.push_back(2'h1);
			end
			tick(40);
			chk_vec(6'({o_right_amp_enable, o_left_amp_enable, o_key_sense_en, o_preamp_en,
				o_mic_bias_en}), 6'({s[2] | s[4], s[1] | s[3], {3{s[0]}}}));
			i_ramp_disable_bit = 1'b1;
			i_volume = 6'($urandom_range(63, 1));
			tick(2);
			chk_vec(o_level, i_volume);
			chk_bit(o_amp_mute, 1'b0);
			i_mute = 1'($urandom);
			i_volume = i_mute ? i_volume : 6'h00;
			tick(1);
			chk_bit(o_amp_mute, 1'b1);
			chk_vec(o_level, 6'h00);
			i_mute = 1'b0;
			i_volume = 6'h00;
			tick(1);
			i_ramp_disable_bit = 1'b0;
			clear_flags();
			chk_vec(6'(o_flags), 6'h00);
			chk_bit(o_irq, 1'b0);
			i_run_bit = 1'b0;
			exp_q.push_back(2'h2);
			tick(3);
			chk_vec(6'(o_found), 6'(s));
			chk_bit(o_weak_pullup_en, 1'b1);
			if (p == 1) begin
				i_key_pin = 1'b1;
				repeat (20) if (o_flags[3] !== 1'b1) tick(1);
				chk_vec(6'({o_irq, o_flags[3]}), 6'({i_irq_en[3], 1'b1}));
				i_key_pin = 1'b0;
				i_run_bit = 1'b1;
				exp_q.push_back(2'h0);
				tick(3);
				i_run_bit = 1'b0;
			end
			i_det_reset = 1'b1;
			i_jack_pin = 1'b0;
			if (p != 1) exp_q.push_back(2'h0);
			tick(3);
			chk_bit(o_plug_test_en, 1'b0);
			chk_vec(6'(o_found), 6'h00);
			i_det_reset = 1'b0;
			tick(5);
			clear_flags();
		end
		i_irq_en = 5'h10;
		i_volume = 6'h02;
		repeat (12000) if (o_level !== 6'h01) tick(1);
		n = 0;
		while (o_level !== 6'h02 && n < 12000) begin
			tick(1);
			n++;
		end
		chk_bit(n == jpmc_pkg::STEP_CYCLES, 1'b1);
		tick(3);
		chk_vec(6'({o_irq, o_flags[4]}), 6'h03);
		i_irq_en = 5'h00;
		tick(1);
		chk_bit(o_irq, 1'b0);
		i_ramp_disable_bit = 1'b1;
		i_mute = 1'($urandom);
		i_volume = i_mute ? 6'($urandom) : 6'h00;
		tick(2);
		chk_vec(o_level, 6'h00);
		chk_bit(o_amp_mute, 1'b1);
		complete_run();
	end
endmodule // tb_top
